// [core/gpcde_defs.svh]
// register offsets, widths and reset values for the port c/d/e pin logic
//
// Functional notes
// R01: pullups only act while pin is input
// R02: seven-pin port pullup enable: 1 on, 0 off
// R03: spi/timer port pullup enable: 1 on, 0 off
// R04: data latches keep contents through reset
// R05: reset clears spi/timer port direction bits
// R06: direction 1 drives latch, 0 floats pin
// R07: spi/timer data read: latch or pin per direction
// R08: latch writes always land, never alter input
// R09: serial/clock data read: latch or pin per direction
// R10: reset clears serial/clock port direction bits
// R11: timer edge/level select claims upper two pins
// R12: spi clock and mosi are gpio when spi off
// R13: spi owns direction, direction bit still picks read
// R14: slave select gpio when spi off or master
// R15: other port direction bit0 ignored when spi on
// R16: pins 3 and 4 become clock out and clock in
// R17: oscillator pins ignore writes, read undefined
// R18: serial pins are gpio when serial interface off
// R19: serial interface owns direction, bit picks read
// R20: software loads latch before setting direction
// R21: pullup enables reset to zero
`ifndef GPCDE_DEFS_SVH
`define GPCDE_DEFS_SVH
`define GPCDE_ADDR_W           16
`define GPCDE_SPT_DATA_ADDR    16'h0003
`define GPCDE_SCP_DATA_ADDR    16'h0008
`define GPCDE_SEVEN_PUE_ADDR   16'h0040
`define GPCDE_SPT_DIR_ADDR     16'h0007
`define GPCDE_SPT_PUE_ADDR     16'h0041
`define GPCDE_SCP_DIR_ADDR     16'h000C
`define GPCDE_SEVEN_W          7
`define GPCDE_SPT_W            8
`define GPCDE_SCP_W            5
`define GPCDE_DIR_RST          8'h00
`define GPCDE_PUE_RST          8'h00
`define GPCDE_SS_BIT           0
`define GPCDE_MOSI_BIT         2
`define GPCDE_SCK_BIT          3
`define GPCDE_TCH0_BIT         6
`define GPCDE_TCH1_BIT         7
`define GPCDE_TXD_BIT          0
`define GPCDE_RXD_BIT          1
`define GPCDE_OSC_OUT_BIT      3
`define GPCDE_OSC_IN_BIT       4
`endif

// [core/gpcde_pkg.sv]
// types for the port c/d/e pin logic
package gpcde_pkg;
  // peripheral overrides arriving from other modules
  typedef struct packed {
    logic       spi_enable_bit;
    logic       spi_master_select;
    logic [1:0] timer_a_ch_active; // edge/level select nonzero, ch1:ch0
    logic [1:0] timer_b_ch_active;
    logic [1:0] timer_a_ch_out;
    logic [1:0] timer_b_ch_out;
    logic [1:0] timer_a_ch_oe;
    logic [1:0] timer_b_ch_oe;
    logic       spi_sck_out;
    logic       spi_sck_oe;
    logic       spi_mosi_out;
    logic       spi_mosi_oe;
    logic       spi_miso_out;
    logic       spi_miso_oe;
    logic       serial_interface_enable;
    logic       serial_txd_out;
    logic       clock_output_sel;
    logic       clock_input_sel;
    logic       clock_output_val;
  } gpcde_ovr_t;
  // per-pin drive: value, enable, pullup
  typedef struct packed {
    logic [7:0] val;
    logic [7:0] oe;
    logic [7:0] pu;
  } gpcde_pin8_t;
  // all register state
  typedef struct packed {
    logic [7:0] spt_data;
    logic [7:0] spt_dir;
    logic [7:0] spt_pue;
    logic [4:0] scp_data;
    logic [4:0] scp_dir;
    logic [6:0] seven_pue;
    logic [7:0] rdata;
    logic [7:0] spt_pin_s1;
    logic [7:0] spt_pin_s2;
    logic [4:0] scp_pin_s1;
    logic [4:0] scp_pin_s2;
  } gpcde_regs_t;
endpackage

// [core/gpcde_pinmux.sv]
// pin ownership mux for the spi/timer and serial/clock ports
`timescale 1ns/100ps
`include "gpcde_defs.svh"
module gpcde_pinmux (
  // register state
  input  wire logic [7:0]           spt_data_in,
  input  wire logic [7:0]           spt_dir_in,
  input  wire logic [7:0]           spt_pue_in,
  input  wire logic [4:0]           scp_data_in,
  input  wire logic [4:0]           scp_dir_in,
  // overrides
  input  wire gpcde_pkg::gpcde_ovr_t ovr_in,
  // pad controls
  output gpcde_pkg::gpcde_pin8_t    spt_pad_out,
  output gpcde_pkg::gpcde_pin8_t    scp_pad_out
);
  logic [7:0] spt_own;
  logic [7:0] spt_pval;
  logic [7:0] spt_poe;
  logic [4:0] scp_own;
  logic [4:0] scp_pval;
  logic [4:0] scp_poe;

  // peripheral ownership and drive of the spi/timer port
  always_comb begin
    spt_own  = 8'h00;
    spt_pval = 8'h00;
    spt_poe  = 8'h00;
    if (ovr_in.spi_enable_bit) begin
      spt_own[`GPCDE_SCK_BIT]  = 1'b1; // R12
      spt_own[`GPCDE_MOSI_BIT] = 1'b1; // R12
      spt_own[1]               = 1'b1;
      // slave select ignores other port direction bit0 here
      spt_own[`GPCDE_SS_BIT]   = ~ovr_in.spi_master_select; // R14 R15
    end
    spt_pval[`GPCDE_SCK_BIT]  = ovr_in.spi_sck_out;
    spt_poe[`GPCDE_SCK_BIT]   = ovr_in.spi_sck_oe;
    spt_pval[`GPCDE_MOSI_BIT] = ovr_in.spi_mosi_out;
    spt_poe[`GPCDE_MOSI_BIT]  = ovr_in.spi_mosi_oe;
    spt_pval[1]               = ovr_in.spi_miso_out;
    spt_poe[1]                = ovr_in.spi_miso_oe;
    // timer a has priority over timer b on the shared pins
    spt_own[7:6]  = ovr_in.timer_a_ch_active | ovr_in.timer_b_ch_active; // R11
    spt_pval[7:6] = ovr_in.timer_a_ch_active != 2'b00 ?
                    ovr_in.timer_a_ch_out : ovr_in.timer_b_ch_out;
    spt_poe[7:6]  = (ovr_in.timer_a_ch_active & ovr_in.timer_a_ch_oe) |
                    (~ovr_in.timer_a_ch_active & ovr_in.timer_b_ch_active
                     & ovr_in.timer_b_ch_oe);
  end

  // ownership of the serial/clock port
  always_comb begin
    scp_own  = 5'h00;
    scp_pval = 5'h00;
    scp_poe  = 5'h00;
    if (ovr_in.serial_interface_enable) begin
      scp_own[`GPCDE_TXD_BIT]  = 1'b1; // R18 R19
      scp_own[`GPCDE_RXD_BIT]  = 1'b1; // R18 R19
      scp_pval[`GPCDE_TXD_BIT] = ovr_in.serial_txd_out;
      scp_poe[`GPCDE_TXD_BIT]  = 1'b1;
    end
    if (ovr_in.clock_output_sel) begin
      scp_own[`GPCDE_OSC_OUT_BIT]  = 1'b1; // R16
      scp_pval[`GPCDE_OSC_OUT_BIT] = ovr_in.clock_output_val;
      scp_poe[`GPCDE_OSC_OUT_BIT]  = 1'b1;
    end
    if (ovr_in.clock_input_sel) begin
      scp_own[`GPCDE_OSC_IN_BIT] = 1'b1; // R16
    end
  end

  // final pad controls; pullups drop whenever the pin drives
  always_comb begin
    spt_pad_out.oe  = (spt_own & spt_poe) | (~spt_own & spt_dir_in); // R13
    spt_pad_out.val = (spt_own & spt_pval) | (~spt_own & spt_data_in); // R06
    spt_pad_out.pu  = spt_pue_in & ~spt_pad_out.oe; // R01 R03
    scp_pad_out.oe  = {3'h0, (scp_own & scp_poe) | (~scp_own & scp_dir_in)};
    scp_pad_out.val = {3'h0, (scp_own & scp_pval) | (~scp_own & scp_data_in)};
    scp_pad_out.pu  = 8'h00;
  end
endmodule

// [core/gpcde_top.sv]
// cpu register file and pin logic for the port c/d/e block
`timescale 1ns/100ps
`include "gpcde_defs.svh"
module gpcde_top (
  // clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  // cpu bus
  input  wire logic [15:0]           addr_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  input  wire logic [7:0]            wdata_in,
  output logic [7:0]                 rdata_out,
  // peripheral overrides
  input  wire gpcde_pkg::gpcde_ovr_t ovr_in,
  // seven-pin port direction, kept elsewhere
  input  wire logic [6:0]            seven_pin_port_direction_in,
  // pins
  input  wire logic [7:0]            spt_pin_in,
  input  wire logic [4:0]            scp_pin_in,
  output logic [7:0]                 spt_pin_out,
  output logic [7:0]                 spt_pin_oe_out,
  output logic [7:0]                 spt_pu_out,
  output logic [4:0]                 scp_pin_out,
  output logic [4:0]                 scp_pin_oe_out,
  output logic [6:0]                 seven_pu_out
);
  gpcde_pkg::gpcde_regs_t r_q;
  gpcde_pkg::gpcde_regs_t r_d;
  gpcde_pkg::gpcde_pin8_t spt_pad;
  gpcde_pkg::gpcde_pin8_t scp_pad;
  logic [7:0]             spt_pad_q;
  logic [7:0]             spt_oe_q;
  logic [7:0]             spt_pu_q;
  logic [4:0]             scp_pad_q;
  logic [4:0]             scp_oe_q;
  logic [6:0]             seven_pu_q;
  logic [4:0]             osc_mask;

  ////////////////////////////////////////////////////////////////////////
  // read mux: latch where direction is 1, synchronised pin otherwise
  function automatic logic [7:0] rd_sel(input logic [7:0] dir,
                                        input logic [7:0] lat,
                                        input logic [7:0] pin);
    rd_sel = (dir & lat) | (~dir & pin);
  endfunction

  gpcde_pinmux u_mux (
    .spt_data_in (r_q.spt_data),
    .spt_dir_in  (r_q.spt_dir),
    .spt_pue_in  (r_q.spt_pue),
    .scp_data_in (r_q.scp_data),
    .scp_dir_in  (r_q.scp_dir),
    .ovr_in      (ovr_in),
    .spt_pad_out (spt_pad),
    .scp_pad_out (scp_pad)
  );

  assign osc_mask = {ovr_in.clock_input_sel, ovr_in.clock_output_sel, 3'h0};

  ////////////////////////////////////////////////////////////////////////
  // next-state logic for registers and synchronisers
  always_comb begin
    r_d = r_q;
    r_d.spt_pin_s1 = spt_pin_in;
    r_d.spt_pin_s2 = r_q.spt_pin_s1;
    r_d.scp_pin_s1 = scp_pin_in;
    r_d.scp_pin_s2 = r_q.scp_pin_s1;
    if (wr_in) begin
      unique case (addr_in)
        `GPCDE_SPT_DATA_ADDR:  r_d.spt_data = wdata_in; // R08
        // oscillator pins swallow writes
        `GPCDE_SCP_DATA_ADDR:  r_d.scp_data = (r_q.scp_data & osc_mask) |
                                   (wdata_in[4:0] & ~osc_mask); // R08 R17
        `GPCDE_SPT_DIR_ADDR:   r_d.spt_dir   = wdata_in;
        `GPCDE_SCP_DIR_ADDR:   r_d.scp_dir   = wdata_in[4:0];
        `GPCDE_SPT_PUE_ADDR:   r_d.spt_pue   = wdata_in; // R03
        `GPCDE_SEVEN_PUE_ADDR: r_d.seven_pue = wdata_in[6:0]; // R02
        default: ;
      endcase
    end
    r_d.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        `GPCDE_SPT_DATA_ADDR:  r_d.rdata = rd_sel(r_q.spt_dir, r_q.spt_data,
                                   r_q.spt_pin_s2); // R07 R13
        // oscillator bits read latch or pin per direction bit: value not meaningful
        `GPCDE_SCP_DATA_ADDR:  r_d.rdata = rd_sel({3'h0, r_q.scp_dir},
                                   {3'h0, r_q.scp_data},
                                   {3'h0, r_q.scp_pin_s2}); // R09 R19 R17
        `GPCDE_SPT_DIR_ADDR:   r_d.rdata = r_q.spt_dir;
        `GPCDE_SCP_DIR_ADDR:   r_d.rdata = {3'h0, r_q.scp_dir};
        `GPCDE_SPT_PUE_ADDR:   r_d.rdata = r_q.spt_pue;
        `GPCDE_SEVEN_PUE_ADDR: r_d.rdata = {1'b0, r_q.seven_pue};
        default:               r_d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; data latches are left untouched by reset
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r_q.spt_dir    <= `GPCDE_DIR_RST; // R05
      r_q.scp_dir    <= 5'h00; // R10
      r_q.spt_pue    <= `GPCDE_PUE_RST; // R21
      r_q.seven_pue  <= 7'h00; // R21
      r_q.rdata      <= 8'h00;
      r_q.spt_data   <= r_d.spt_data; // R04
      r_q.scp_data   <= r_d.scp_data; // R04
      r_q.spt_pin_s1 <= r_d.spt_pin_s1;
      r_q.spt_pin_s2 <= r_d.spt_pin_s2;
      r_q.scp_pin_s1 <= r_d.scp_pin_s1;
      r_q.scp_pin_s2 <= r_d.scp_pin_s2;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pad outputs; pullups drop while a pin drives
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      spt_pad_q  <= 8'h00;
      spt_oe_q   <= 8'h00;
      spt_pu_q   <= 8'h00;
      scp_pad_q  <= 5'h00;
      scp_oe_q   <= 5'h00;
      seven_pu_q <= 7'h00;
    end else begin
      spt_pad_q  <= spt_pad.val;
      spt_oe_q   <= spt_pad.oe;
      spt_pu_q   <= spt_pad.pu; // R01
      scp_pad_q  <= scp_pad.val[4:0];
      scp_oe_q   <= scp_pad.oe[4:0];
      seven_pu_q <= r_q.seven_pue & ~seven_pin_port_direction_in; // R01 R02
    end
  end

  assign rdata_out      = r_q.rdata;
  assign spt_pin_out    = spt_pad_q;
  assign spt_pin_oe_out = spt_oe_q;
  assign spt_pu_out     = spt_pu_q;
  assign scp_pin_out    = scp_pad_q;
  assign scp_pin_oe_out = scp_oe_q;
  assign seven_pu_out   = seven_pu_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  a_pullup_off_out: assert property (@(posedge clk_in) disable iff (srst_in)
    (spt_pu_out & spt_pin_oe_out) == 8'h00) // R01
    else $error("pullup active on driving pin");
  a_seven_pullup: assert property (@(posedge clk_in) disable iff (srst_in)
    ##1 seven_pu_out == ($past(r_q.seven_pue) &
      ~$past(seven_pin_port_direction_in))) // R02
    else $error("seven-pin pullup wrong");
  a_spt_pue_wr: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == `GPCDE_SPT_PUE_ADDR |=> r_q.spt_pue == $past(wdata_in))
    else $error("pullup enable not written"); // R03
  a_dir_reset: assert property (@(posedge clk_in)
    srst_in |=> r_q.spt_dir == 8'h00 && r_q.scp_dir == 5'h00) // R05
    else $error("direction not cleared");
  a_latch_keep: assert property (@(posedge clk_in)
    srst_in && !wr_in |=> $stable(r_q.spt_data)) // R04
    else $error("latch changed by reset");
  a_gpio_drive: assert property (@(posedge clk_in) disable iff (srst_in)
    !ovr_in.spi_enable_bit && ovr_in.timer_a_ch_active == 2'b00 &&
    ovr_in.timer_b_ch_active == 2'b00 |=> spt_pin_oe_out == $past(r_q.spt_dir))
    else $error("gpio enable not direction"); // R06
  a_spt_read: assert property (@(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == `GPCDE_SPT_DATA_ADDR |=> rdata_out ==
      (($past(r_q.spt_dir) & $past(r_q.spt_data)) |
       (~$past(r_q.spt_dir) & $past(r_q.spt_pin_s2)))) // R07
    else $error("port read wrong");
  a_latch_write: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == `GPCDE_SPT_DATA_ADDR |=> r_q.spt_data ==
      $past(wdata_in)) // R08
    else $error("latch write lost");
  a_scp_read: assert property (@(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == `GPCDE_SCP_DATA_ADDR |=> rdata_out[7:5] == 3'h0)
    else $error("serial port read high bits"); // R09
  a_osc_write: assert property (@(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == `GPCDE_SCP_DATA_ADDR && ovr_in.clock_output_sel
    |=> r_q.scp_data[3] == $past(r_q.scp_data[3])) // R17
    else $error("oscillator latch written");
  a_sck_gpio: assert property (@(posedge clk_in) disable iff (srst_in)
    !ovr_in.spi_enable_bit |=> spt_pin_oe_out[3] == $past(r_q.spt_dir[3]))
    else $error("clock pin not gpio"); // R12
  a_spi_own: assert property (@(posedge clk_in) disable iff (srst_in)
    ovr_in.spi_enable_bit && !ovr_in.spi_master_select |=>
      spt_pin_oe_out[0] == 1'b0) // R13 R14 R15
    else $error("slave select driven");
  a_serial_gpio: assert property (@(posedge clk_in) disable iff (srst_in)
    !ovr_in.serial_interface_enable && !ovr_in.clock_output_sel |=>
      scp_pin_oe_out[3:0] == $past(r_q.scp_dir[3:0])) // R18 R19
    else $error("serial pins not gpio");
  a_clk_out: assert property (@(posedge clk_in) disable iff (srst_in)
    ovr_in.clock_output_sel |=> scp_pin_oe_out[3]) // R16
    else $error("clock output not driven");
  a_timer_own: assert property (@(posedge clk_in) disable iff (srst_in)
    ovr_in.timer_a_ch_active[1] |=>
      spt_pin_oe_out[7] == $past(ovr_in.timer_a_ch_oe[1])) // R11
    else $error("timer pin ownership");

  ////////////////////////////////////////////////////////////////////////
  // register writes and reset values
  a_spt_dir_wr: assert property ( // R06
    @(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == `GPCDE_SPT_DIR_ADDR |=>
      r_q.spt_dir == $past(wdata_in))
    else $error("direction not written");
  a_scp_dir_wr: assert property ( // R10
    @(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == `GPCDE_SCP_DIR_ADDR |=>
      r_q.scp_dir == $past(wdata_in[4:0]))
    else $error("serial port direction not written");
  a_seven_pue_wr: assert property ( // R02
    @(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == `GPCDE_SEVEN_PUE_ADDR |=>
      r_q.seven_pue == $past(wdata_in[6:0]))
    else $error("seven-pin pullup enable not written");
  a_pue_reset: assert property ( // R21
    @(posedge clk_in)
    srst_in |=>
      r_q.spt_pue == 8'h00 && r_q.seven_pue == 7'h00)
    else $error("pullup enable not cleared");
  a_scp_keep: assert property ( // R04
    @(posedge clk_in)
    srst_in && !wr_in |=>
      $stable(r_q.scp_data))
    else $error("serial latch changed by reset");

  // read data stands one cycle, then returns to zero
  a_rd_idle: assert property ( // R07
    @(posedge clk_in) disable iff (srst_in)
    !rd_in |=>
      rdata_out == 8'h00)
    else $error("read data without read");
  a_scp_read_val: assert property ( // R09
    @(posedge clk_in) disable iff (srst_in)
    rd_in && addr_in == `GPCDE_SCP_DATA_ADDR |=> rdata_out[4:0] ==
      (($past(r_q.scp_dir) & $past(r_q.scp_data)) |
       (~$past(r_q.scp_dir) & $past(r_q.scp_pin_s2))))
    else $error("serial port read wrong");
  a_scp_latch_wr: assert property ( // R08
    @(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == `GPCDE_SCP_DATA_ADDR &&
    !ovr_in.clock_output_sel && !ovr_in.clock_input_sel |=>
      r_q.scp_data == $past(wdata_in[4:0]))
    else $error("serial latch write lost");

  // oscillator and serial pins leave the direction bits behind
  a_osc_in_write: assert property ( // R17
    @(posedge clk_in) disable iff (srst_in)
    wr_in && addr_in == `GPCDE_SCP_DATA_ADDR && ovr_in.clock_input_sel
    |=> r_q.scp_data[4] == $past(r_q.scp_data[4]))
    else $error("clock input latch written");
  a_osc_in_float: assert property ( // R16
    @(posedge clk_in) disable iff (srst_in)
    ovr_in.clock_input_sel |=>
      !scp_pin_oe_out[4])
    else $error("clock input pin driven");
  a_txd_drive: assert property ( // R18
    @(posedge clk_in) disable iff (srst_in)
    ovr_in.serial_interface_enable |=> scp_pin_oe_out[0] &&
      scp_pin_out[0] == $past(ovr_in.serial_txd_out))
    else $error("transmit pin not driven");
  a_rxd_input: assert property ( // R19
    @(posedge clk_in) disable iff (srst_in)
    ovr_in.serial_interface_enable |=>
      !scp_pin_oe_out[1])
    else $error("receive pin driven");

  // pullups of the spi/timer port drop on every driving pin
  a_spt_pullup: assert property ( // R03
    @(posedge clk_in) disable iff (srst_in)
    ##1 spt_pu_out ==
      ($past(r_q.spt_pue) & ~spt_pin_oe_out))
    else $error("spi/timer pullup wrong");

  // spi and timer ownership of the spi/timer port
  a_mosi_gpio: assert property ( // R12
    @(posedge clk_in) disable iff (srst_in)
    !ovr_in.spi_enable_bit |=>
      spt_pin_oe_out[2] == $past(r_q.spt_dir[2]))
    else $error("data pin not gpio");
  a_ss_master: assert property ( // R14
    @(posedge clk_in) disable iff (srst_in)
    ovr_in.spi_enable_bit && ovr_in.spi_master_select |=>
      spt_pin_oe_out[0] == $past(r_q.spt_dir[0]))
    else $error("slave select not gpio as master");
  a_miso_own: assert property ( // R13
    @(posedge clk_in) disable iff (srst_in)
    ovr_in.spi_enable_bit |=>
      spt_pin_oe_out[1] == $past(ovr_in.spi_miso_oe))
    else $error("slave data pin not owned");
  a_sck_spi: assert property ( // R13
    @(posedge clk_in) disable iff (srst_in)
    ovr_in.spi_enable_bit |=>
      spt_pin_oe_out[3] == $past(ovr_in.spi_sck_oe) &&
      spt_pin_out[3] == $past(ovr_in.spi_sck_out))
    else $error("clock pin not owned");
  a_timer_b_own: assert property ( // R11
    @(posedge clk_in) disable iff (srst_in)
    ovr_in.timer_b_ch_active[1] && ovr_in.timer_a_ch_active == 2'b00 |=>
      spt_pin_oe_out[7] == $past(ovr_in.timer_b_ch_oe[1]) &&
      spt_pin_out[7] == $past(ovr_in.timer_b_ch_out[1]))
    else $error("second timer pin ownership");

  // main scenarios
  c_spt_read: cover property (@(posedge clk_in)
    rd_in && addr_in == `GPCDE_SPT_DATA_ADDR);
  c_spi_on: cover property (@(posedge clk_in) ovr_in.spi_enable_bit);
  c_osc_on: cover property (@(posedge clk_in) ovr_in.clock_input_sel);
  c_ss_master: cover property (@(posedge clk_in)
    ovr_in.spi_enable_bit && ovr_in.spi_master_select);
  c_timer_b: cover property (@(posedge clk_in)
    ovr_in.timer_b_ch_active[1]);
endmodule

// [testbench/gpcde_board.sv]
// board model: pads and external drivers on the port pins, pullups on the spi/timer port pins
`timescale 1ns/100ps
module gpcde_board (
  // clock
  input  wire logic       clk_in,
  // spi/timer port pads and board drive
  input  wire logic [7:0] spt_val_in,
  input  wire logic [7:0] spt_oe_in,
  input  wire logic [7:0] spt_pu_in,
  input  wire logic [7:0] spt_ext_in,
  input  wire logic [7:0] spt_xen_in,
  output logic      [7:0] spt_pin_out,
  // serial/clock port pads and board drive
  input  wire logic [4:0] scp_val_in,
  input  wire logic [4:0] scp_oe_in,
  input  wire logic [4:0] scp_ext_in,
  input  wire logic [4:0] scp_xen_in,
  output logic      [4:0] scp_pin_out
);
  logic [7:0] tog_q;
  ////////////////////////////////////////////////////////////////////
  // a floating pin wanders so that it never reads as a stale level
  always_ff @(posedge clk_in) begin
    tog_q <= (tog_q === 8'hAA) ? 8'h55 : 8'hAA;
  end
  // pad drive wins, then board drive, then pullup (spi/timer port only), else floating
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      spt_pin_out[i] = spt_oe_in[i] ? spt_val_in[i] :
                       spt_xen_in[i] ? spt_ext_in[i] :
                       spt_pu_in[i] ? 1'b1 : tog_q[i];
    end
    for (int i = 0; i < 5; i++) begin
      scp_pin_out[i] = scp_oe_in[i] ? scp_val_in[i] :
                       scp_xen_in[i] ? scp_ext_in[i] : tog_q[i];
    end
  end
endmodule

// [testbench/gpcde_top_test.sv]
// self-checking testbench for the port c/d/e pin logic
`timescale 1ns/100ps
`include "gpcde_defs.svh"
module gpcde_top_test;
  logic clk_in, srst_in, wr_in, rd_in;
  logic [15:0] addr_in;
  logic [7:0] wdata_in, rdata_out, spt_pin_in, spt_val, spt_oe, spt_pu;
  logic [7:0] spt_ext, spt_xen;
  logic [4:0] scp_pin_in, scp_val, scp_oe, scp_ext, scp_xen;
  logic [6:0] sev_dir, sev_pu;
  gpcde_pkg::gpcde_ovr_t ovr;
  int error_cnt = 0;
  int checks_done = 0;
  ////////////////////////////////////////////////////////////////////
  // clock, design and board
  always #50 clk_in = ~clk_in;
  gpcde_top i_dut (.clk_in(clk_in), .srst_in(srst_in),
    .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in),
    .wdata_in(wdata_in), .rdata_out(rdata_out), .ovr_in(ovr),
    .seven_pin_port_direction_in(sev_dir), .spt_pin_in(spt_pin_in),
    .scp_pin_in(scp_pin_in), .spt_pin_out(spt_val),
    .spt_pin_oe_out(spt_oe), .spt_pu_out(spt_pu),
    .scp_pin_out(scp_val), .scp_pin_oe_out(scp_oe),
    .seven_pu_out(sev_pu));
  gpcde_board i_board (.clk_in(clk_in), .spt_val_in(spt_val),
    .spt_oe_in(spt_oe), .spt_pu_in(spt_pu), .spt_ext_in(spt_ext),
    .spt_xen_in(spt_xen), .spt_pin_out(spt_pin_in),
    .scp_val_in(scp_val), .scp_oe_in(scp_oe), .scp_ext_in(scp_ext),
    .scp_xen_in(scp_xen), .scp_pin_out(scp_pin_in));
  ////////////////////////////////////////////////////////////////////
  // bus cycles and comparison helpers
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic rchk(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    chk($sformatf("read %h", a), e, rdata_out);
  endtask
  // pads lag registers and pins pass two sync flops
  task automatic settle;
    repeat (3) @(posedge clk_in);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    rchk(`GPCDE_SPT_DIR_ADDR, 8'h00);
    rchk(`GPCDE_SCP_DIR_ADDR, 8'h00);
    rchk(`GPCDE_SPT_PUE_ADDR, 8'h00);
    rchk(`GPCDE_SEVEN_PUE_ADDR, 8'h00);
    chk("spt oe", 8'h00, spt_oe);
  endtask
  task automatic t_pullup;
    wr(`GPCDE_SPT_PUE_ADDR, 8'h3C);
    wr(`GPCDE_SPT_DIR_ADDR, 8'h0F);
    sev_dir <= 7'h0F;
    wr(`GPCDE_SEVEN_PUE_ADDR, 8'h7F);
    settle();
    chk("spt pu", 8'h30, spt_pu);
    chk("seven pu", 8'h70, {1'b0, sev_pu});
  endtask
  task automatic t_port_d;
    wr(`GPCDE_SPT_DATA_ADDR, 8'hA5);
    wr(`GPCDE_SPT_DIR_ADDR, 8'hF0);
    spt_xen <= 8'h0F;
    spt_ext <= 8'h3C;
    settle();
    chk("spt oe", 8'hF0, spt_oe);
    chk("spt val", 8'hA0, spt_val & 8'hF0);
    rchk(`GPCDE_SPT_DATA_ADDR, 8'hAC);
    wr(`GPCDE_SPT_DATA_ADDR, 8'h5A);
    rchk(`GPCDE_SPT_DATA_ADDR, 8'h5C);
    wr(`GPCDE_SPT_DIR_ADDR, 8'hFF);
    rchk(`GPCDE_SPT_DATA_ADDR, 8'h5A);
  endtask
  task automatic t_port_e;
    wr(`GPCDE_SCP_DATA_ADDR, 8'h15);
    wr(`GPCDE_SCP_DIR_ADDR, 8'h07);
    scp_xen <= 5'h1F;
    scp_ext <= 5'h0A;
    settle();
    chk("scp oe", 8'h07, {3'h0, scp_oe});
    rchk(`GPCDE_SCP_DATA_ADDR, 8'h0D);
  endtask
  // spi claims clock and data pins, slave select follows master bit
  task automatic t_spi;
    wr(`GPCDE_SPT_DIR_ADDR, 8'h01);
    spt_xen <= 8'hFF;
    spt_ext <= 8'hF0;
    ovr.spi_enable_bit <= 1'b1;
    ovr.spi_sck_oe <= 1'b1;
    ovr.spi_sck_out <= 1'b1;
    ovr.spi_mosi_oe <= 1'b1;
    settle();
    chk("spi oe", 8'h0C, spt_oe);
    chk("spi val", 8'h08, spt_val & 8'h0C);
    rchk(`GPCDE_SPT_DATA_ADDR, 8'hF8);
    ovr.spi_master_select <= 1'b1;
    settle();
    chk("master oe", 8'h0D, spt_oe);
    ovr.spi_enable_bit <= 1'b0;
    ovr.timer_b_ch_active <= 2'b10;
    ovr.timer_b_ch_oe <= 2'b10;
    ovr.timer_b_ch_out <= 2'b10;
    settle();
    chk("timer oe", 8'h81, spt_oe);
    chk("timer val", 8'h80, spt_val & 8'h80);
  endtask
  // serial pins and oscillator pins override the direction bits
  task automatic t_serial;
    wr(`GPCDE_SCP_DIR_ADDR, 8'h1A);
    ovr.serial_interface_enable <= 1'b1;
    ovr.serial_txd_out <= 1'b1;
    ovr.clock_output_sel <= 1'b1;
    ovr.clock_output_val <= 1'b1;
    ovr.clock_input_sel <= 1'b1;
    settle();
    chk("serial oe", 8'h09, {3'h0, scp_oe});
    chk("serial val", 8'h09, {3'h0, scp_val & 5'h09});
    wr(`GPCDE_SCP_DATA_ADDR, 8'h1F);
    ovr <= '0;
    wr(`GPCDE_SCP_DIR_ADDR, 8'h1F);
    settle();
    chk("gpio oe", 8'h1F, {3'h0, scp_oe});
    rchk(`GPCDE_SCP_DATA_ADDR, 8'h17);
  endtask
  // a reset mid-run clears direction but keeps the latch
  task automatic t_keep;
    wr(`GPCDE_SPT_DATA_ADDR, 8'h3C);
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    srst_in <= 1'b0;
    rchk(`GPCDE_SPT_DIR_ADDR, 8'h00);
    wr(`GPCDE_SPT_DIR_ADDR, 8'hFF);
    rchk(`GPCDE_SPT_DATA_ADDR, 8'h3C);
  endtask
  ////////////////////////////////////////////////////////////////////
  // verdict and run control
  task automatic end_of_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    clk_in = 1'b0;
    srst_in = 1'b1;
    {wr_in, rd_in, addr_in, wdata_in} = '0;
    {spt_ext, spt_xen, scp_ext, scp_xen, sev_dir} = '0;
    ovr = '0;
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    #1;
    t_reset();
    t_pullup();
    t_port_d();
    t_port_e();
    t_spi();
    t_serial();
    t_keep();
    end_of_test();
  end
  // the scenarios need well under a thousand cycles
  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end
endmodule
